// ===== common/ssf_pkg.sv
`default_nettype none
package ssf_pkg;
   // register byte offsets on the apb slave
   localparam logic [7:0] OFF_STATUS    = 8'h00;
   localparam logic [7:0] OFF_CTRL      = 8'h04;
   localparam logic [7:0] OFF_TXBUF     = 8'h08;
   localparam logic [7:0] OFF_RXBUF     = 8'h0c;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h10;
   localparam logic [7:0] OFF_IRQ_MASK  = 8'h14;
   // serial_status layout and value after reset or low-power entry
   localparam logic [7:0] STATUS_RESET  = 8'h84;
   localparam int unsigned BIT_TX_HOLDING_EMPTY_FLAG     = 7;
   localparam int unsigned BIT_RX_FULL_FLAG     = 6;
   localparam int unsigned BIT_OVR      = 5;
   localparam int unsigned BIT_FRM      = 4;
   localparam int unsigned BIT_PAR      = 3;
   localparam int unsigned BIT_TX_DONE_FLAG     = 2;
   localparam int unsigned BIT_MP_BIT_RECEIVED     = 1;
   localparam int unsigned BIT_MP_BIT_TO_SEND     = 0;
   // control register layout
   localparam int unsigned CTRL_W       = 5;
   localparam logic [4:0] CTRL_RESET    = 5'h00;
   localparam int unsigned CTL_TX_ON    = 0;
   localparam int unsigned CTL_RX_ON    = 1;
   localparam int unsigned CTL_PAR_ODD  = 2;
   localparam int unsigned CTL_PAR_EN   = 3;
   localparam int unsigned CTL_SYNC     = 4;
   // interrupt status / mask layout
   localparam int unsigned IRQ_W        = 4;
   localparam logic [3:0] IRQ_RESET     = 4'h0;
   localparam int unsigned IRQ_TXE      = 0;
   localparam int unsigned IRQ_RXF      = 1;
   localparam int unsigned IRQ_ERR      = 2;
   localparam int unsigned IRQ_TX_DONE_FLAG     = 3;
   // data buffers
   localparam logic [7:0] BUF_RESET     = 8'h00;
endpackage
`default_nettype wire

// ===== src/ssf_status.sv
// Function
// - reset and low-power load status with 84h
// - sticky flags clear by read-1 then write-0
// - transmit-end and received mp bit read-only
// - tx-empty cleared by write-0 or buffer write
// - tx-empty set on shifter load or tx off
// - rx-full cleared by write-0 or buffer read
// - rx-full set on error-free character
// - rx-full kept on error or rx off
// - overrun on full buffer, new character dropped
// - overrun halts rx, and tx in sync
// - error flags kept on rx off
// - framing error when stop bit is zero, async mode only
// - only first stop bit is checked
// - framing error loads buffer, halts rx, and tx in sync
// - parity error on parity mismatch
// - parity error loads buffer, halts rx, and tx in sync
// - transmit-end cleared with tx-empty, set on last bit with tx-empty set or on tx off
`timescale 1ns/1ps
`default_nettype none
module ssf_status (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // standby, watch, subactive or subsleep entry
   input  wire logic        low_power_i,
   // transmit shifter side
   input  wire logic        tx_load_i,
   input  wire logic        tx_last_bit_i,
   output logic [7:0]       tx_data_o,
   output logic             tx_data_valid_o,
   output logic             tx_halt_o,
   output logic             mp_bit_to_send_o,
   // receive shifter side
   input  wire logic        rx_done_i,
   input  wire logic [7:0]  rx_data_i,
   input  wire logic        rx_parity_bit_i,
   input  wire logic        rx_stop_bit_i,
   input  wire logic        rx_mp_bit_i,
   output logic             rx_halt_o,
   // configuration seen by the shifters
   output logic             tx_on_o,
   output logic             rx_on_o,
   output logic             parity_odd_select_o,
   output logic             parity_en_o,
   output logic             sync_mode_o,
   // level interrupt
   output logic             irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // state
   logic                 tx_holding_empty_flag_reg;      // tx_holding_empty_flag
   logic                 rx_full_flag_reg;      // rx_full_flag
   logic                 ovr_reg;       // overrun_flag
   logic                 frm_reg;       // framing_flag
   logic                 par_reg;       // parity_fault_flag
   logic                 tx_done_flag_reg;      // tx_done_flag
   logic                 mp_bit_received_reg;      // mp_bit_received
   logic                 mp_bit_to_send_reg;      // mp_bit_to_send
   logic [4:0]           arm_reg;       // flag read as 1, clear allowed
   logic [ssf_pkg::CTRL_W-1:0] ctrl_reg; // serial_ctrl_reg
   logic [7:0]           tx_buf_reg;    // tx_holding_buf
   logic [7:0]           rx_buf_reg;    // rx_holding_buf
   logic [ssf_pkg::IRQ_W-1:0]  irq_stat_reg; // sticky events
   logic [ssf_pkg::IRQ_W-1:0]  irq_mask_reg; // event enables
   logic [31:0]          prdata_reg;    // read data captured in setup

   // set wins over clear in every hardware-set flag
   function automatic logic flag_next(input logic cur,
                                      input logic set,
                                      input logic clr);
      flag_next = set | (cur & ~clr);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   wire       setup_ph  = psel_i & ~penable_i;
   wire       access_ph = psel_i & penable_i;
   wire       wr_acc    = access_ph & pwrite_i;
   wire       rd_acc    = access_ph & ~pwrite_i;
   wire       hit_stat  = (paddr_i == ssf_pkg::OFF_STATUS);
   wire       hit_ctrl  = (paddr_i == ssf_pkg::OFF_CTRL);
   wire       hit_txbuf = (paddr_i == ssf_pkg::OFF_TXBUF);
   wire       hit_rxbuf = (paddr_i == ssf_pkg::OFF_RXBUF);
   wire       hit_istat = (paddr_i == ssf_pkg::OFF_IRQ_STAT);
   wire       hit_imask = (paddr_i == ssf_pkg::OFF_IRQ_MASK);
   wire       mapped    = hit_stat | hit_ctrl | hit_txbuf | hit_rxbuf |
                          hit_istat | hit_imask;

   // control fields
   wire       tx_on    = ctrl_reg[ssf_pkg::CTL_TX_ON];
   wire       rx_on    = ctrl_reg[ssf_pkg::CTL_RX_ON];
   wire       par_odd  = ctrl_reg[ssf_pkg::CTL_PAR_ODD];
   wire       par_en   = ctrl_reg[ssf_pkg::CTL_PAR_EN];
   wire       sync_md  = ctrl_reg[ssf_pkg::CTL_SYNC];

   wire [7:0] status_now = {tx_holding_empty_flag_reg, rx_full_flag_reg, ovr_reg, frm_reg, par_reg,
                            tx_done_flag_reg, mp_bit_received_reg, mp_bit_to_send_reg};

   // read mux; unmapped addresses read as zero
   wire [31:0] rd_mux =
      hit_stat  ? {24'h000000, status_now} :
      hit_ctrl  ? {27'h0000000, ctrl_reg} :
      hit_txbuf ? {24'h000000, tx_buf_reg} :
      hit_rxbuf ? {24'h000000, rx_buf_reg} :
      hit_istat ? {28'h0000000, irq_stat_reg} :
      hit_imask ? {28'h0000000, irq_mask_reg} : 32'h00000000;

   ////////////////////////////////////////////////////////////////////////
   // software clears: a write of 0 only counts if the flag was read as 1
   wire       wr_stat  = wr_acc & hit_stat;
   wire [4:0] sw_clr   = {5{wr_stat}} & ~pwdata_i[7:3] & arm_reg;
   wire       rd_arm   = rd_acc & hit_stat;

   ////////////////////////////////////////////////////////////////////////
   // receive path
   wire rx_halt  = ovr_reg | frm_reg | par_reg;
   wire accept   = rx_done_i & rx_on & ~rx_halt;
   // only the first stop bit arrives here; the second is never checked
   wire frm_bad  = ~sync_md & ~rx_stop_bit_i;
   wire par_bad  = par_en & ((^{rx_data_i, rx_parity_bit_i}) != par_odd);
   wire ovr_set  = accept & rx_full_flag_reg;
   wire rx_load  = accept & ~rx_full_flag_reg;
   wire rx_full_flag_set = rx_load & ~frm_bad & ~par_bad;
   wire frm_set  = rx_load & frm_bad;
   wire par_set  = rx_load & par_bad;
   wire rx_full_flag_clr = sw_clr[3] | (rd_acc & hit_rxbuf);

   ////////////////////////////////////////////////////////////////////////
   // transmit path
   wire tx_holding_empty_flag_set = tx_load_i | ~tx_on;
   wire tx_holding_empty_flag_clr = sw_clr[4] | (wr_acc & hit_txbuf);
   wire tx_done_flag_set = ~tx_on | (tx_last_bit_i & tx_holding_empty_flag_reg);
   wire tx_done_flag_clr = tx_holding_empty_flag_clr;

   // next flag values
   wire tx_holding_empty_flag_n = flag_next(tx_holding_empty_flag_reg, tx_holding_empty_flag_set, tx_holding_empty_flag_clr);
   wire rx_full_flag_n = flag_next(rx_full_flag_reg, rx_full_flag_set, rx_full_flag_clr);
   wire ovr_n  = flag_next(ovr_reg, ovr_set, sw_clr[2]);
   wire frm_n  = flag_next(frm_reg, frm_set, sw_clr[1]);
   wire par_n  = flag_next(par_reg, par_set, sw_clr[0]);
   wire tx_done_flag_n = flag_next(tx_done_flag_reg, tx_done_flag_set, tx_done_flag_clr);

   // interrupt events
   wire [3:0] irq_ev = {tx_done_flag_set & ~tx_done_flag_reg,
                        ovr_set | frm_set | par_set,
                        rx_full_flag_set,
                        tx_holding_empty_flag_set & ~tx_holding_empty_flag_reg};
   wire [3:0] irq_rd_clr = (rd_acc & hit_istat) ? prdata_reg[3:0] : 4'h0;

   ////////////////////////////////////////////////////////////////////////
   // status flags; low-power entry reloads the reset image
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         {tx_holding_empty_flag_reg, rx_full_flag_reg, ovr_reg, frm_reg, par_reg, tx_done_flag_reg, mp_bit_received_reg,
          mp_bit_to_send_reg} <= ssf_pkg::STATUS_RESET;
      end else if (low_power_i) begin
         {tx_holding_empty_flag_reg, rx_full_flag_reg, ovr_reg, frm_reg, par_reg, tx_done_flag_reg, mp_bit_received_reg,
          mp_bit_to_send_reg} <= ssf_pkg::STATUS_RESET;
      end else begin
         tx_holding_empty_flag_reg <= tx_holding_empty_flag_n;
         rx_full_flag_reg <= rx_full_flag_n;
         ovr_reg  <= ovr_n;
         frm_reg  <= frm_n;
         par_reg  <= par_n;
         tx_done_flag_reg <= tx_done_flag_n;
         // received mp bit follows characters loaded into the buffer only
         if (rx_load) mp_bit_received_reg <= rx_mp_bit_i;
         if (wr_stat) mp_bit_to_send_reg <= pwdata_i[ssf_pkg::BIT_MP_BIT_TO_SEND];
      end
   end

   // arm bits drop together with their flag
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         arm_reg <= 5'h00;
      end else if (low_power_i) begin
         arm_reg <= 5'h00;
      end else begin
         arm_reg <= (arm_reg | ({5{rd_arm}} & prdata_reg[7:3])) &
                    {tx_holding_empty_flag_n, rx_full_flag_n, ovr_n, frm_n, par_n};
      end
   end

   // buffers; an overrun leaves the old character in place
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_buf_reg <= ssf_pkg::BUF_RESET;
         rx_buf_reg <= ssf_pkg::BUF_RESET;
      end else begin
         if (wr_acc & hit_txbuf) tx_buf_reg <= pwdata_i[7:0];
         if (rx_load) rx_buf_reg <= rx_data_i;
      end
   end

   // control, mask and interrupt status registers
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl_reg     <= ssf_pkg::CTRL_RESET;
         irq_mask_reg <= ssf_pkg::IRQ_RESET;
         irq_stat_reg <= ssf_pkg::IRQ_RESET;
      end else begin
         if (wr_acc & hit_ctrl) ctrl_reg <= pwdata_i[ssf_pkg::CTRL_W-1:0];
         if (wr_acc & hit_imask)
            irq_mask_reg <= pwdata_i[ssf_pkg::IRQ_W-1:0];
         // only bits that were returned are cleared, new events win
         irq_stat_reg <= irq_ev | (irq_stat_reg & ~irq_rd_clr);
      end
   end

   // read data is taken in the setup cycle so it comes from a flop
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_reg <= 32'h00000000;
      end else if (setup_ph & ~pwrite_i) begin
         prdata_reg <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata_o            = prdata_reg;
   assign pready_o            = access_ph;   // zero wait states
   assign pslverr_o           = access_ph & ~mapped;
   assign tx_data_o           = tx_buf_reg;
   // in sync mode a receive error freezes the transmitter too
   assign tx_halt_o           = sync_md & rx_halt;
   assign tx_data_valid_o     = ~tx_holding_empty_flag_reg & tx_on & ~tx_halt_o;
   assign mp_bit_to_send_o    = mp_bit_to_send_reg;
   assign rx_halt_o           = rx_halt;
   assign tx_on_o             = tx_on;
   assign rx_on_o             = rx_on;
   assign parity_odd_select_o = par_odd;
   assign parity_en_o         = par_en;
   assign sync_mode_o         = sync_md;
   assign irq_o               = |(irq_stat_reg & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_stat_read_rx_full_flag;
      rd_acc & hit_stat & prdata_reg[ssf_pkg::BIT_RX_FULL_FLAG] & ~low_power_i;
   endsequence
   sequence s_stat_write_zero;
      wr_stat & ~pwdata_i[ssf_pkg::BIT_RX_FULL_FLAG] & ~rx_full_flag_set & ~low_power_i;
   endsequence
   // a character that the receiver is free to take this cycle
   sequence s_char_taken;
      rx_done_i & rx_on & ~rx_halt & ~rx_full_flag_reg & ~low_power_i;
   endsequence
   // a status write outside low-power entry
   sequence s_quiet_stat_write;
      wr_stat & ~low_power_i;
   endsequence

   chk_lp_reinit: assert property (
      low_power_i |=> status_now == ssf_pkg::STATUS_RESET)
      else $error("status not reloaded on low-power entry");
   chk_rx_full_flag_read_clr: assert property (
      s_stat_read_rx_full_flag ##1 ~low_power_i [*2] ##1 s_stat_write_zero
      |=> ~rx_full_flag_reg)
      else $error("read-one write-zero did not clear rx-full");
   chk_write_one: assert property (
      rx_full_flag_reg & wr_stat & pwdata_i[ssf_pkg::BIT_RX_FULL_FLAG] & ~low_power_i
      |=> rx_full_flag_reg)
      else $error("write of one cleared rx-full");
   chk_tx_done_flag_ro: assert property (
      wr_stat & ~tx_done_flag_set & ~tx_done_flag_clr & ~low_power_i |=> $stable(tx_done_flag_reg))
      else $error("cpu write changed transmit-end");
   chk_txbuf_clears: assert property (
      wr_acc & hit_txbuf & tx_on & ~tx_load_i & ~tx_last_bit_i & ~low_power_i
      |=> ~tx_holding_empty_flag_reg & ~tx_done_flag_reg)
      else $error("buffer write left tx-empty or transmit-end set");
   chk_tx_off_sets: assert property (
      ~tx_on |=> tx_holding_empty_flag_reg & tx_done_flag_reg)
      else $error("tx off did not set tx-empty and transmit-end");
   chk_rx_good: assert property (
      rx_full_flag_set & ~low_power_i |=> rx_full_flag_reg & rx_buf_reg == $past(rx_data_i))
      else $error("good character not stored as full");
   chk_overrun: assert property (
      accept & rx_full_flag_reg & ~low_power_i
      |=> ovr_reg & $stable(rx_buf_reg))
      else $error("overrun not flagged or buffer overwritten");
   chk_halted: assert property (
      rx_halt & ~low_power_i |=> $stable(rx_buf_reg) & ~$rose(rx_full_flag_reg))
      else $error("reception continued while an error flag was set");
   chk_frame_err: assert property (
      frm_set & ~low_power_i |=> frm_reg & ~rx_full_flag_reg & rx_halt_o)
      else $error("framing error handling wrong");
   chk_parity_err: assert property (
      par_set & ~low_power_i |=> par_reg & ~rx_full_flag_reg)
      else $error("parity error handling wrong");
   chk_set_wins: assert property (
      tx_holding_empty_flag_set & tx_holding_empty_flag_clr & ~low_power_i |=> tx_holding_empty_flag_reg)
      else $error("clear beat a hardware set of tx-empty");

   ////////////////////////////////////////////////////////////////////////
   // further checks on the flag rules

   // cpu writes never reach the received mp bit
   chk_mp_bit_received_ro: assert property (
      s_quiet_stat_write ##0 ~rx_load |=> $stable(mp_bit_received_reg))
      else $error("cpu write changed the received mp bit");

   // a write of one never clears tx-empty
   chk_wr_one_tx_holding_empty_flag: assert property (
      tx_holding_empty_flag_reg & wr_stat & pwdata_i[ssf_pkg::BIT_TX_HOLDING_EMPTY_FLAG] & ~low_power_i
      |=> tx_holding_empty_flag_reg)
      else $error("write of one cleared tx-empty");

   // an empty holding buffer is never offered while tx-empty is up
   chk_tx_valid: assert property (
      tx_holding_empty_flag_reg |-> ~tx_data_valid_o)
      else $error("empty holding buffer offered to the shifter");

   // shifter load always leaves tx-empty set
   chk_tx_holding_empty_flag_load: assert property (
      tx_load_i & ~low_power_i |=> tx_holding_empty_flag_reg)
      else $error("shifter load did not set tx-empty");

   // reading the holding buffer drops rx-full unless a new char lands
   chk_rxbuf_read: assert property (
      rd_acc & hit_rxbuf & ~rx_full_flag_set & ~low_power_i |=> ~rx_full_flag_reg)
      else $error("buffer read left rx-full set");

   // a bad character never raises rx-full
   chk_err_no_full: assert property (
      s_char_taken ##0 (frm_bad | par_bad) |=> ~rx_full_flag_reg)
      else $error("rx-full set on a bad character");

   // in sync mode an error flag freezes the transmitter as well
   chk_sync_halt: assert property (
      sync_md & rx_halt |-> tx_halt_o & ~tx_data_valid_o)
      else $error("transmitter not frozen by error in sync mode");

   // switching the receiver off keeps every error flag
   chk_rx_off_keeps: assert property (
      ~rx_on & ~wr_stat & ~low_power_i
      |=> $stable({ovr_reg, frm_reg, par_reg}))
      else $error("error flags changed while receiver off");

   // a zero first stop bit in async mode flags framing, data still lands
   chk_frm_set: assert property (
      s_char_taken ##0 (~sync_md & ~rx_stop_bit_i)
      |=> frm_reg & rx_buf_reg == $past(rx_data_i))
      else $error("framing error not flagged or data not stored");

   // parity mismatch against the selected sense raises the flag
   chk_par_set: assert property (
      s_char_taken ##0
      (par_en & ((^{rx_data_i, rx_parity_bit_i}) != par_odd)) |=> par_reg)
      else $error("parity error not flagged");

   // last bit out with nothing waiting ends the transmission
   chk_tx_done_flag_set: assert property (
      tx_last_bit_i & tx_holding_empty_flag_reg & ~low_power_i |=> tx_done_flag_reg)
      else $error("transmit-end not set after the last bit");

   // low-power entry forgets every earlier status read
   chk_lp_arm: assert property (
      low_power_i |=> arm_reg == 5'h00)
      else $error("clear permission survived low-power entry");

endmodule // ssf_status
`default_nettype wire

// ===== testbench/ssf_shifter_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the tx and rx shifters beyond the status block
module ssf_shifter_model (
   input  wire logic       clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       tx_valid_i,
   input  wire logic       tx_stall_i,
   output logic            tx_load_o,
   output logic            tx_last_o,
   output var logic        rx_done_o,
   output var logic [7:0]  rx_data_o,
   output var logic        rx_par_o,
   output var logic        rx_stop_o,
   output var logic        rx_mp_o
);
   logic [1:0] tx_cnt; // bit times left before the last bit
   ////////////////////////////////////////////////////////////////////
   // take a character only when offered; stall models a slow shifter
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_load_o <= 1'b0;
         tx_last_o <= 1'b0;
         tx_cnt    <= 2'h0;
      end else begin
         tx_load_o <= tx_valid_i & ~tx_load_o & ~tx_stall_i;
         tx_last_o <= (tx_cnt == 2'h1);
         if (tx_load_o) begin
            tx_cnt <= 2'h3;
         end else if (tx_cnt != 2'h0) begin
            tx_cnt <= tx_cnt - 2'h1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // idle receive lines at time zero
   initial begin
      rx_done_o = 1'b0;
      rx_data_o = 8'h00;
      rx_par_o  = 1'b0;
      rx_stop_o = 1'b1;
      rx_mp_o   = 1'b0;
   end
   // one finished character; lines flip after so stale data never helps
   task automatic send(input logic [7:0] d, input logic p, input logic s,
                       input logic m);
      @(posedge clk_i);
      rx_done_o <= 1'b1;
      rx_data_o <= d;
      rx_par_o  <= p;
      rx_stop_o <= s;
      rx_mp_o   <= m;
      @(posedge clk_i);
      rx_done_o <= 1'b0;
      rx_data_o <= ~d;
      rx_par_o  <= ~p;
      rx_stop_o <= ~s;
      rx_mp_o   <= ~m;
   endtask
endmodule // ssf_shifter_model
`default_nettype wire

// ===== testbench/ssf_status_test.sv
`timescale 1ns/1ps
`default_nettype none
module ssf_status_test;
   localparam logic [7:0] ST = ssf_pkg::OFF_STATUS; // short aliases
   localparam logic [7:0] CT = ssf_pkg::OFF_CTRL;
   localparam logic [7:0] TB = ssf_pkg::OFF_TXBUF;
   localparam logic [7:0] RB = ssf_pkg::OFF_RXBUF;
   logic        clk_i, rst_b_i, psel_i, penable_i, pwrite_i, low_power_i;
   logic        pready_o, pslverr_o, tx_load_i, tx_last_bit_i, stall, e;
   logic        tx_data_valid_o, rx_done_i, rx_parity_bit_i, rx_stop_bit_i;
   logic        rx_mp_bit_i, irq_o;
   logic [7:0]  paddr_i, tx_data_o, rx_data_i;
   logic [31:0] pwdata_i, prdata_o, d;
   int          fails, n_checks;
   ssf_status i_ssf_status (.clk_i, .rst_b_i, .psel_i, .penable_i,
      .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
      .low_power_i, .tx_load_i, .tx_last_bit_i, .tx_data_o,
      .tx_data_valid_o, .tx_halt_o(), .mp_bit_to_send_o(), .rx_done_i,
      .rx_data_i, .rx_parity_bit_i, .rx_stop_bit_i, .rx_mp_bit_i,
      .rx_halt_o(), .tx_on_o(), .rx_on_o(), .parity_odd_select_o(),
      .parity_en_o(), .sync_mode_o(), .irq_o);
   ssf_shifter_model i_ssf_shifter_model (.clk_i, .rst_b_i,
      .tx_valid_i(tx_data_valid_o), .tx_stall_i(stall),
      .tx_load_o(tx_load_i), .tx_last_o(tx_last_bit_i),
      .rx_done_o(rx_done_i), .rx_data_o(rx_data_i),
      .rx_par_o(rx_parity_bit_i), .rx_stop_o(rx_stop_bit_i),
      .rx_mp_o(rx_mp_bit_i));
   ////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task end_sim();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, x, s);
      end
   endtask
   // one apb transfer; no wait count assumed, only the bench bound
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int k;
      @(posedge clk_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge clk_i);
         if (pready_o === 1'b1) break;
      end
      d = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      if (k == 16) begin
         fails++;
         end_sim();
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] v);
      apb(1'b1, a, {24'h0, v});
   endtask
   task rd(input logic [7:0] a, input logic [7:0] x);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), d, {24'h0, x});
   endtask
   // the shifter finishes in its own time: poll under a bound
   task poll(input logic [7:0] x);
      repeat (20) begin
         apb(1'b0, ST, 32'h0);
         if (d === {24'h0, x}) break;
      end
      chk("status poll", d, {24'h0, x});
   endtask
   task send(input logic [7:0] v, input logic p, input logic s);
      i_ssf_shifter_model.send(v, p, s, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      {rst_b_i, psel_i, penable_i, pwrite_i, low_power_i} = 5'h00;
      {paddr_i, pwdata_i} = 40'h0;
      stall = 1'b1;
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd(ST, 8'h84);
      wr(ST, 8'hff);
      rd(ST, 8'h85);
      wr(ST, 8'h00);
      rd(ST, 8'h84);
      $display("test reset done");
      wr(CT, 8'h0b);
      wr(TB, 8'h5a);
      rd(ST, 8'h00);
      chk("tx data", {24'h0, tx_data_o}, 32'h5a);
      stall <= 1'b0;
      poll(8'h84);
      wr(ST, 8'h7e);
      rd(ST, 8'h00);
      wr(TB, 8'h11);
      poll(8'h84);
      $display("test transmit done");
      i_ssf_shifter_model.send(8'h03, 1'b0, 1'b1, 1'b1);
      rd(ST, 8'hc6);
      rd(RB, 8'h03);
      rd(ST, 8'h86);
      send(8'h21, 1'b0, 1'b1);
      send(8'h30, 1'b0, 1'b1);
      rd(ST, 8'he4);
      send(8'h44, 1'b0, 1'b1);
      wr(CT, 8'h09);
      rd(ST, 8'he4);
      wr(CT, 8'h0b);
      wr(ST, 8'hde);
      rd(ST, 8'hc4);
      rd(RB, 8'h21);
      $display("test overrun done");
      send(8'h0f, 1'b0, 1'b0);
      wr(ST, 8'hee);
      rd(ST, 8'h94);
      rd(RB, 8'h0f);
      wr(ST, 8'hee);
      rd(ST, 8'h84);
      wr(CT, 8'h0f);
      send(8'h03, 1'b0, 1'b1);
      rd(ST, 8'h8c);
      rd(RB, 8'h03);
      wr(ST, 8'hf6);
      send(8'h03, 1'b1, 1'b1);
      rd(ST, 8'hc4);
      rd(RB, 8'h03);
      $display("test errors done");
      wr(ssf_pkg::OFF_IRQ_MASK, 8'h02);
      rd(ssf_pkg::OFF_IRQ_STAT, 8'h0f);
      @(negedge clk_i);
      chk("irq idle", {31'h0, irq_o}, 32'h0);
      send(8'h01, 1'b0, 1'b1);
      @(negedge clk_i);
      chk("irq raised", {31'h0, irq_o}, 32'h1);
      rd(ssf_pkg::OFF_IRQ_STAT, 8'h02);
      @(negedge clk_i);
      chk("irq cleared", {31'h0, irq_o}, 32'h0);
      wr(ssf_pkg::OFF_IRQ_MASK, 8'h00);
      rd(RB, 8'h01);
      send(8'h01, 1'b0, 1'b1);
      @(negedge clk_i);
      chk("irq masked", {31'h0, irq_o}, 32'h0);
      rd(8'h20, 8'h00);
      chk("slverr", {31'h0, e}, 32'h1);
      $display("test irq done");
      stall <= 1'b1;
      wr(TB, 8'h66);
      rd(ST, 8'h40);
      wr(CT, 8'h0e);
      rd(ST, 8'hc4);
      wr(ST, 8'hbe);
      rd(ST, 8'h84);
      @(posedge clk_i);
      low_power_i <= 1'b1;
      @(posedge clk_i);
      low_power_i <= 1'b0;
      rd(ST, 8'h84);
      $display("test low power done");
      wr(CT, 8'h1f);
      send(8'h03, 1'b0, 1'b1);
      wr(TB, 8'h77);
      stall <= 1'b0;
      rd(ST, 8'h08);
      $display("test sync halt done");
      end_sim();
   end
endmodule // ssf_status_test
`default_nettype wire
